/* rtl/lpb_pkg.sv */
// Purpose: Shared constants and types for the loop port bypass control
// Assumes: One 250 MHz core clock; straps are static levels
// Notes: Port count, interval and filter depth are fixed
package lpb_pkg;
  localparam int unsigned NUM_PORTS = 5;
  localparam int unsigned INTERVAL_LOG2 = 15;
  localparam logic [15:0] INTERVAL_BITS = 16'h8000;
  localparam logic [2:0] FILTER_DEPTH = 3'h4;
  localparam logic [2:0] SINGLE_DEPTH = 3'h1;
  localparam logic [4:0] INSERT_RST = 5'h1F;
  localparam logic [15:0] REF_FAST_KHZ = 16'h9F04;
  localparam logic [15:0] REF_SLOW_KHZ = 16'h4F82;
  localparam logic [2:0] LOCK_WAIT_CYC = 3'h4;

  // Static strap group
  typedef struct packed {
    logic ref_rate_sel;
    logic valid_check_src_sel;
    logic recovery_insert_sel;
    logic line_rate_sel;
    logic equalizer_sel;
    logic output_gate_sel;
    logic valid_filter_sel;
  } lpb_straps_s;

  // Recovery stage state
  typedef enum logic [1:0] {
    LPB_IDLE = 2'b00,
    LPB_ACQ = 2'b01,
    LPB_LOCK = 2'b10
  } lpb_cdr_e;
endpackage

/* rtl/lpb_valid_mon.sv */
// Purpose: Data-valid monitor flagging errors over fixed bit intervals
// Assumes: bit_en pulses once per recovered bit
// Notes: Flag updates only at interval boundaries
`timescale 1ns/1ps
module lpb_valid_mon (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Stream
  input wire logic bit_en,
  input wire logic char_err,
  input wire logic filter_sel,
  // Result
  output logic data_valid
);
  logic [15:0] bit_cnt_q;
  logic err_seen_q;
  logic [2:0] bad_run_q;
  logic [2:0] good_run_q;
  logic valid_q;
  logic boundary;
  logic bad_int;
  logic [2:0] depth;
  logic [2:0] bad_nxt;
  logic [2:0] good_nxt;

  // Interval end and depth decode
  assign boundary = bit_en && (bit_cnt_q == lpb_pkg::INTERVAL_BITS - 16'h1);
  assign bad_int = err_seen_q || (bit_en && char_err);
  assign depth = filter_sel ? lpb_pkg::FILTER_DEPTH
                            : lpb_pkg::SINGLE_DEPTH;
  // Saturating runs; clamp so a filter change cannot wrap them
  assign bad_nxt = bad_int ? ((bad_run_q >= depth) ? depth
                              : bad_run_q + 3'h1) : 3'h0;
  assign good_nxt = !bad_int ? ((good_run_q >= depth) ? depth
                                : good_run_q + 3'h1) : 3'h0;

  // Bit counting in recovered-clock cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 16'h0;
      err_seen_q <= 1'b0;
    end else if (bit_en) begin
      bit_cnt_q <= boundary ? 16'h0 : bit_cnt_q + 16'h1;
      err_seen_q <= boundary ? 1'b0 : bad_int;
    end
  end

  // Flag update at boundaries only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bad_run_q <= 3'h0;
      good_run_q <= 3'h0;
      valid_q <= 1'b0;
    end else if (boundary) begin
      bad_run_q <= bad_nxt;
      good_run_q <= good_nxt;
      if (bad_nxt >= depth) begin
        valid_q <= 1'b0;
      end else if (good_nxt >= depth) begin
        valid_q <= 1'b1;
      end
    end
  end

  assign data_valid = valid_q;
endmodule

/* rtl/lpb_top.sv */
// Purpose: Five-port loop port bypass switch control with recovery stage
// Assumes: Straps and stream strobes are synchronous to clk
// Notes: Undriven straps are modelled as already pulled high upstream;
//   every strap except the two valid monitor selects reaches its output one edge after it is sampled;
//   recovery status inputs are abstract strobes, not analog lock;
//   the valid monitor is frozen whenever the recovery is unlocked
`timescale 1ns/1ps
module lpb_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Straps
  input wire logic [4:0] port_insert_n_pu,
  input wire lpb_pkg::lpb_straps_s straps,
  input wire logic [4:0] port_select_term_x,
  // Recovery stage status
  input wire logic ref_edge,
  input wire logic freq_ok,
  input wire logic data_edge,
  // Received stream strobes
  input wire logic bit_en,
  input wire logic [4:0] port_char_err,
  // Switch controls
  output logic [4:0] loop_switch_cell,
  output logic cdr_in_path,
  output logic line_rate_fast,
  output logic [15:0] ref_expect_khz,
  output logic [4:0] eq_enable,
  output logic [4:0] port_tx_x_en,
  output logic cdr_locked,
  output logic port0_data_valid
);
  // Registered controls, recovery state and decode wires
  logic [4:0] insert_q;
  logic cdr_q;
  logic rate_q;
  logic [15:0] ref_q;
  logic [4:0] eq_q;
  logic [4:0] tx_q;
  lpb_pkg::lpb_cdr_e st_q;
  lpb_pkg::lpb_cdr_e st_d;
  logic [2:0] wait_q;
  logic mon_err;
  logic valid_w;
  logic [4:0] eq_d;
  logic [4:0] tx_d;
  logic [15:0] ref_sel_code;
  logic lock_entry;
  logic mon_bit_en;

  // Port stays enabled unless global and per-port terms are both low
  function automatic logic term_gate(input logic global_sel,
                                     input logic port_term);
    return global_sel || port_term;
  endfunction

  // Per-port equalizer and output gating
  genvar g;
  generate
    for (g = 0; g < lpb_pkg::NUM_PORTS; g++) begin : g_port
      assign eq_d[g] = term_gate(straps.equalizer_sel,
                                 port_select_term_x[g]);
      assign tx_d[g] = term_gate(straps.output_gate_sel,
                                 port_select_term_x[g]);
    end
  endgenerate

  // Error source: port 0 after recovery, else any port
  assign mon_err = straps.valid_check_src_sel ? port_char_err[0]
                   : |port_char_err;

  // Reference code select; the fast code is a tag, not a kHz count
  assign ref_sel_code = straps.ref_rate_sel ? lpb_pkg::REF_FAST_KHZ
                                            : lpb_pkg::REF_SLOW_KHZ;

  // Lock entry needs settled frequency, full dwell and a data edge
  assign lock_entry = freq_ok && data_edge
                      && (wait_q == lpb_pkg::LOCK_WAIT_CYC);

  // Bits before lock are untrusted, so the monitor stays frozen
  assign mon_bit_en = bit_en && (st_q == lpb_pkg::LPB_LOCK);

  // Insert straps; a floating pin reads high, so reset bypasses
  // every port and each disk joins the loop only once its pin goes low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      insert_q <= lpb_pkg::INSERT_RST;
    end else begin
      insert_q <= port_insert_n_pu;
    end
  end

  // Recovery placement and line rate follow their straps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cdr_q <= 1'b1;
      rate_q <= 1'b1;
    end else begin
      cdr_q <= straps.recovery_insert_sel;
      rate_q <= straps.line_rate_sel;
    end
  end

  // Expected reference code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q <= lpb_pkg::REF_FAST_KHZ;
    end else begin
      ref_q <= ref_sel_code;
    end
  end

  // Equalizer and transmit enables, registered per port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eq_q <= 5'h1F;
      tx_q <= 5'h1F;
    end else begin
      eq_q <= eq_d;
      tx_q <= tx_d;
    end
  end

  // Recovery: reference acquisition precedes data lock
  always_comb begin
    st_d = st_q;
    case (st_q)
      lpb_pkg::LPB_IDLE: begin
        if (ref_edge) begin
          st_d = lpb_pkg::LPB_ACQ;
        end
      end
      lpb_pkg::LPB_ACQ: begin
        if (lock_entry) begin
          st_d = lpb_pkg::LPB_LOCK;
        end
      end
      lpb_pkg::LPB_LOCK: begin
        if (!freq_ok) begin
          st_d = lpb_pkg::LPB_ACQ;
        end
      end
      default: begin
        st_d = lpb_pkg::LPB_IDLE;
      end
    endcase
  end

  // Recovery state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= lpb_pkg::LPB_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Dwell counts reference edges only; a frequency drop restarts it
  // so a marginal reference cannot creep into lock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 3'h0;
    end else if (st_q != lpb_pkg::LPB_ACQ || !freq_ok) begin
      wait_q <= 3'h0;
    end else if (ref_edge && wait_q != lpb_pkg::LOCK_WAIT_CYC) begin
      wait_q <= wait_q + 3'h1;
    end
  end

  // Monitor sees bits only while locked; its interval count is
  // held, not cleared, across a lock loss
  lpb_valid_mon u_mon (
    .clk(clk),
    .rst_n(rst_n),
    .bit_en(mon_bit_en),
    .char_err(mon_err),
    .filter_sel(straps.valid_filter_sel),
    .data_valid(valid_w)
  );

  // Lock status from a flop, one edge behind the state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cdr_locked <= 1'b0;
    end else begin
      cdr_locked <= (st_q == lpb_pkg::LPB_LOCK);
    end
  end

  // Valid flag retimed so the output comes from a top-level flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_data_valid <= 1'b0;
    end else begin
      port0_data_valid <= valid_w;
    end
  end

  // Remaining outputs copy their flops
  assign loop_switch_cell = insert_q;
  assign cdr_in_path = cdr_q;
  assign line_rate_fast = rate_q;
  assign ref_expect_khz = ref_q;
  assign eq_enable = eq_q;
  assign port_tx_x_en = tx_q;
endmodule

/* testbench/lpb_properties.sv */
// Purpose: Port checks for lpb_top
// Assumes: One clock, straps are levels
// Notes: Static outputs lag their straps by one edge
`timescale 1ns/1ps
module lpb_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Inputs
  input wire logic [4:0] port_insert_n_pu,
  input wire lpb_pkg::lpb_straps_s straps,
  input wire logic [4:0] port_select_term_x,
  input wire logic freq_ok,
  input wire logic data_edge,
  input wire logic bit_en,
  // Outputs
  input wire logic [4:0] loop_switch_cell,
  input wire logic cdr_in_path,
  input wire logic line_rate_fast,
  input wire logic [15:0] ref_expect_khz,
  input wire logic [4:0] eq_enable,
  input wire logic [4:0] port_tx_x_en,
  input wire logic cdr_locked,
  input wire logic port0_data_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Lock held while frequency is lost
  sequence s_unlock;
    cdr_locked && !freq_ok;
  endsequence
  // First edge after reset still shows reset values
  a_insert_follow: assert property ($past(rst_n) |->
    loop_switch_cell == $past(port_insert_n_pu)) else $error("insert");
  a_eq_term: assert property ($past(rst_n) |->
    eq_enable == $past({5{straps.equalizer_sel}} | port_select_term_x))
    else $error("eq");
  a_tx_gate: assert property ($past(rst_n) |->
    port_tx_x_en == $past({5{straps.output_gate_sel}} | port_select_term_x))
    else $error("tx");
  a_cdr_path: assert property ($past(rst_n) |->
    cdr_in_path == $past(straps.recovery_insert_sel)) else $error("cdr");
  a_rate_sel: assert property ($past(rst_n) |->
    line_rate_fast == $past(straps.line_rate_sel)) else $error("rate");
  a_ref_code: assert property ($past(rst_n) |-> ref_expect_khz ==
    ($past(straps.ref_rate_sel) ? lpb_pkg::REF_FAST_KHZ
                                : lpb_pkg::REF_SLOW_KHZ)) else $error("ref");
  a_lock_cause: assert property ($rose(cdr_locked) |->
    $past(freq_ok, 2) && $past(data_edge, 2)) else $error("lock");
  a_lock_loss: assert property (s_unlock |-> ##2 !cdr_locked)
    else $error("unlock");
  a_valid_edge: assert property ($changed(port0_data_valid) |->
    $past(bit_en, 2)) else $error("valid");
endmodule

/* testbench/lpb_loop_model.sv */
// Purpose: Far side source of reference and stream
// Assumes: Bench requests acquisition and errors
// Notes: Recovered bits arrive every cycle
`timescale 1ns/1ps
module lpb_loop_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench controls
  input wire logic ref_fast,
  input wire logic acq_en,
  input wire logic [4:0] err_req,
  // Toward the block
  output logic ref_edge,
  output logic freq_ok,
  output logic data_edge,
  output logic bit_en,
  output logic [4:0] port_char_err
);
  logic [1:0] div_q;
  // Reference divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) div_q <= 2'h0;
    else div_q <= div_q + 2'h1;
  end
  // Slow reference at half the fast rate
  assign ref_edge = ref_fast ? div_q[0] : (div_q == 2'h3);
  assign freq_ok = acq_en;
  assign data_edge = acq_en & div_q[0];
  assign bit_en = rst_n;
  assign port_char_err = err_req;
endmodule

/* testbench/lpb_top_tb.sv */
// Purpose: Self-checking bench for lpb_top
// Assumes: 250 MHz clock, seed 88
// Notes: Filter high is checked holding through one bad interval
`timescale 1ns/1ps
module lpb_top_tb;
  logic clk, rst_n, acq, re, fo, de, be, cp, rt, lk, dv;
  logic [4:0] ins, term, er, pce, lsc, eq, tx;
  logic [15:0] rk;
  lpb_pkg::lpb_straps_s st;
  int error_cnt, checks_done;
  lpb_top u_lpb_top (.clk(clk), .rst_n(rst_n), .port_insert_n_pu(ins),
    .straps(st), .port_select_term_x(term), .ref_edge(re), .freq_ok(fo),
    .data_edge(de), .bit_en(be), .port_char_err(pce),
    .loop_switch_cell(lsc), .cdr_in_path(cp), .line_rate_fast(rt),
    .ref_expect_khz(rk), .eq_enable(eq), .port_tx_x_en(tx),
    .cdr_locked(lk), .port0_data_valid(dv));
  lpb_loop_model u_lpb_loop_model (.clk(clk), .rst_n(rst_n),
    .ref_fast(st.ref_rate_sel), .acq_en(acq), .err_req(er), .ref_edge(re),
    .freq_ok(fo), .data_edge(de), .bit_en(be), .port_char_err(pce));
  // Per-port enable: strap high or term high
  function automatic logic [4:0] gate(input logic s, input logic [4:0] t);
    return {5{s}} | t;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait on lock or valid
  task automatic wait_for(input bit sel, input logic v, input int lim);
    int n;
    n = 0;
    while ((sel ? dv : lk) !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if ((sel ? dv : lk) !== v) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    ins = 5'h1F;
    st = '1;
    term = 5'h00;
    acq = 1'b0;
    er = 5'h00;
    error_cnt = 0;
    checks_done = 0;
    void'($urandom(88));
    repeat (2) @(posedge clk);
    chk({lsc, eq, tx, lk}, 16'hFFFE);
    chk(rk, lpb_pkg::REF_FAST_KHZ);
    rst_n <= 1'b1;
    // Random straps, first two all-off and all-on with terms held low
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      ins <= (i < 2) ? {5{i[0]}} : 5'($urandom);
      st <= (i < 2) ? {7{i[0]}} : 7'($urandom);
      term <= (i < 2) ? 5'h00 : 5'($urandom);
      @(posedge clk);
      #1;
      chk(16'({lsc, cp, rt}), 16'({ins, st[4], st[3]}));
      chk(rk, st.ref_rate_sel ? lpb_pkg::REF_FAST_KHZ
                              : lpb_pkg::REF_SLOW_KHZ);
      chk(16'({eq, tx}), 16'({gate(st[2], term), gate(st[1], term)}));
    end
    @(posedge clk);
    st <= 7'h7E;
    acq <= 1'b1;
    wait_for(1'b0, 1'b1, 200);
    chk(16'(lk), 16'h1);
    // Interval 1: port 2 error ignored while port 0 is the source
    @(posedge clk);
    er <= 5'h04;
    @(posedge clk);
    er <= 5'h00;
    wait_for(1'b1, 1'b1, 33000);
    chk(16'(dv), 16'h1);
    // Interval 2: filter high, one bad interval keeps the flag up
    @(posedge clk);
    st <= 7'h7F;
    er <= 5'h01;
    @(posedge clk);
    er <= 5'h00;
    repeat (32800) @(posedge clk);
    #1;
    chk(16'(dv), 16'h1);
    // Interval 3: filter low, all ports as source, port 3 error
    @(posedge clk);
    st <= 7'h5E;
    er <= 5'h08;
    @(posedge clk);
    er <= 5'h00;
    repeat (100) @(posedge clk);
    #1;
    chk(16'(dv), 16'h1);
    wait_for(1'b1, 1'b0, 33000);
    chk(16'(dv), 16'h0);
    @(posedge clk);
    acq <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(16'(lk), 16'h0);
    print_verdict();
  end
endmodule
bind lpb_top lpb_properties u_lpb_properties (.clk(clk), .rst_n(rst_n),
  .port_insert_n_pu(port_insert_n_pu), .straps(straps),
  .port_select_term_x(port_select_term_x), .freq_ok(freq_ok),
  .data_edge(data_edge), .bit_en(bit_en),
  .loop_switch_cell(loop_switch_cell), .cdr_in_path(cdr_in_path),
  .line_rate_fast(line_rate_fast), .ref_expect_khz(ref_expect_khz),
  .eq_enable(eq_enable), .port_tx_x_en(port_tx_x_en),
  .cdr_locked(cdr_locked), .port0_data_valid(port0_data_valid));
